// ---- src/srbp_cfg.svh ----
// constants for the burst sram read port: widths, pin slots, reset values
`ifndef SRBP_CFG_SVH
`define SRBP_CFG_SVH

// ==========================================================================
// data path sizes
`define SRBP_WORD_W   18
`define SRBP_BYTE_W   9
`define SRBP_BWS_W    2
`define SRBP_BURST    4
`define SRBP_LINE_W   72
`define SRBP_ADDR_W   20
`define SRBP_DEPTH    1048576

// ==========================================================================
// positions of each pin inside the synchronised pin vector
`define SRBP_PIN_KP   0
`define SRBP_PIN_KN   1
`define SRBP_PIN_CP   2
`define SRBP_PIN_CN   3
`define SRBP_PIN_DLL  4
`define SRBP_PIN_RPS  5
`define SRBP_PIN_WPS  6
`define SRBP_PIN_BWS  7
`define SRBP_PIN_ADDR 9
`define SRBP_PIN_D    29
`define SRBP_SYNC_W   47

// ==========================================================================
// reset values and the index of the last burst word
`define SRBP_RST_Q      18'H00000
`define SRBP_RST_OE     1'H0
`define SRBP_RST_SINGLE 1'H0
`define SRBP_LAST_WORD  2'H3

`endif

// ---- src/srbp_pkg.sv ----
// types shared by the burst sram read port files
package srbp_pkg;

    typedef logic [17:0] srbp_word_t;
    typedef logic [71:0] srbp_line_t;
    typedef logic [1:0]  srbp_idx_t;

    typedef enum logic [1:0] {
        SRBP_OUT_IDLE,
        SRBP_OUT_RUN,
        SRBP_OUT_DRAIN
    } srbp_out_st_t;

endpackage : srbp_pkg

// ---- src/srbp_sync.sv ----
// two flip-flop synchroniser for every pin that enters the core clock domain
`timescale 1ns/1ns
`default_nettype none
`include "srbp_cfg.svh"

module srbp_sync (
    input  wire logic                     i_clk,  // core clock
    input  wire logic [`SRBP_SYNC_W-1:0]  i_d,    // raw pins
    output logic      [`SRBP_SYNC_W-1:0]  o_q     // synchronised pins
);

    logic [`SRBP_SYNC_W-1:0] meta;

    // no reset: the single clock strap must pass through while reset is held
    always_ff @(posedge i_clk) begin
        meta <= i_d;
        o_q  <= meta;
    end

endmodule : srbp_sync
`default_nettype wire

// ---- src/srbp_read_port.sv ----
// burst sram core: read port with burst output sequencer, write capture, array
`timescale 1ns/1ns
`default_nettype none
`include "srbp_cfg.svh"

// Notes on behaviour
// - loop enabled: first read word appears one and a half input cycles after acceptance.
// - loop disabled: first read word appears one input cycle after acceptance.
// - reads and writes start only on a positive input clock rise.
// - write data captured on rises of positive and negative input clocks.
// - port selects and byte selects registered on input clock rises.
// - read data launched on output clock rises, or input clock rises in single mode.
// - every access is a four word burst of eighteen bit words.
// - array is four one mega-word by eighteen banks; one address picks four words.
// - read select low at input rise stores that address as the read address.
// - after the next input rise the lowest word goes out on the output clock.
// - each further output rise sends the next word until four are out.
// - a read request on the rise right after an accepted read is ignored.
// - reads every other cycle give one word on every output rise, no gaps.
// - deselected port finishes reads, then floats outputs after next positive output rise.
// - other widths keep four transfers per access in two cycles.
// - separate read and write data ports share one address bus.
module srbp_read_port (
    input  wire logic                     i_clk,                  // core clock
    input  wire logic                     i_srst,                 // sync reset
    input  wire logic                     i_in_clk_pos,           // positive input clock
    input  wire logic                     i_in_clk_neg,           // negative input clock
    input  wire logic                     i_out_clk_pos,          // positive output clock
    input  wire logic                     i_out_clk_neg,          // negative output clock
    input  wire logic                     i_loop_disable_n,       // low: legacy latency
    input  wire logic                     i_read_port_select_n,   // read request
    input  wire logic                     i_write_port_select_n,  // write request
    input  wire logic [`SRBP_BWS_W-1:0]   i_byte_write_select_n,  // byte lanes
    input  wire logic [`SRBP_ADDR_W-1:0]  i_addr,                 // shared address
    input  wire logic [`SRBP_WORD_W-1:0]  i_d,                    // write data
    output logic      [`SRBP_WORD_W-1:0]  o_q,                    // read data
    output logic                          o_q_oe                  // read data driven
);

    // ======================================================================
    // helpers
    function automatic srbp_pkg::srbp_word_t get_word(
        input srbp_pkg::srbp_line_t line,
        input srbp_pkg::srbp_idx_t  idx
    );
        unique case (idx)
            2'H0: get_word = line[17:0];
            2'H1: get_word = line[35:18];
            2'H2: get_word = line[53:36];
            2'H3: get_word = line[71:54];
        endcase
    endfunction : get_word

    function automatic srbp_pkg::srbp_word_t merge_word(
        input srbp_pkg::srbp_word_t  old_w,
        input srbp_pkg::srbp_word_t  new_w,
        input logic [`SRBP_BWS_W-1:0] mask_n
    );
        merge_word = old_w;
        if (!mask_n[0]) merge_word[`SRBP_BYTE_W-1:0] = new_w[`SRBP_BYTE_W-1:0];
        if (!mask_n[1]) merge_word[`SRBP_WORD_W-1:`SRBP_BYTE_W] =
            new_w[`SRBP_WORD_W-1:`SRBP_BYTE_W];
    endfunction : merge_word

    // ======================================================================
    // pin synchronisers and clock edge detection
    logic [`SRBP_SYNC_W-1:0] pins;
    logic [3:0]              clk_prev;

    srbp_sync u_sync (
        .i_clk  (i_clk),
        .i_d    ({i_d, i_addr, i_byte_write_select_n, i_write_port_select_n,
                  i_read_port_select_n, i_loop_disable_n, i_out_clk_neg,
                  i_out_clk_pos, i_in_clk_neg, i_in_clk_pos}),
        .o_q    (pins)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            clk_prev <= 4'HF;
        end else begin
            clk_prev <= pins[`SRBP_PIN_CN:`SRBP_PIN_KP];
        end
    end

    logic                     k_rise;
    logic                     kn_rise;
    logic                     c_rise;
    logic                     cn_rise;
    logic                     dll_on;
    logic                     rps_n;
    logic                     wps_n;
    logic [`SRBP_BWS_W-1:0]   bws_n;
    logic [`SRBP_ADDR_W-1:0]  addr;
    srbp_pkg::srbp_word_t     din;

    assign k_rise  = pins[`SRBP_PIN_KP] & ~clk_prev[0];
    assign kn_rise = pins[`SRBP_PIN_KN] & ~clk_prev[1];
    assign c_rise  = pins[`SRBP_PIN_CP] & ~clk_prev[2];
    assign cn_rise = pins[`SRBP_PIN_CN] & ~clk_prev[3];
    assign dll_on  = pins[`SRBP_PIN_DLL];
    assign rps_n   = pins[`SRBP_PIN_RPS];
    assign wps_n   = pins[`SRBP_PIN_WPS];
    assign bws_n   = pins[`SRBP_PIN_BWS +: `SRBP_BWS_W];
    assign addr    = pins[`SRBP_PIN_ADDR +: `SRBP_ADDR_W];
    assign din     = pins[`SRBP_PIN_D +: `SRBP_WORD_W];

    // ======================================================================
    // single clock strap, caught while reset is held
    logic single_mode;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            single_mode <= pins[`SRBP_PIN_CP] & pins[`SRBP_PIN_CN];
        end
    end

    // output launch edges
    logic out_p;
    logic out_n;

    assign out_p = single_mode ? k_rise : c_rise;
    assign out_n = single_mode ? kn_rise : cn_rise;

    // ======================================================================
    // storage: four banks of one mega-word each, side by side in one line
    srbp_pkg::srbp_line_t mem [0:`SRBP_DEPTH-1];

    // ======================================================================
    // read request acceptance
    logic                     rd_last;
    logic                     rd_acc;
    logic                     pend_wait;
    logic                     pend_go;
    logic [`SRBP_ADDR_W-1:0]  pend_addr;
    logic                     start_burst;
    logic                     arm_now;

    assign rd_acc  = k_rise & ~rps_n & ~rd_last;
    assign arm_now = k_rise & pend_wait;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rd_last <= 1'H0;
        end else if (k_rise) begin
            rd_last <= rd_acc;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pend_addr <= '0;
        end else if (rd_acc) begin
            pend_addr <= addr;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pend_wait <= 1'H0;
            pend_go   <= 1'H0;
        end else begin
            if (rd_acc) begin
                pend_wait <= 1'H1;
            end else if (k_rise && pend_wait) begin
                pend_wait <= 1'H0;
            end
            if (start_burst) begin
                pend_go <= 1'H0;
            end else if (arm_now) begin
                pend_go <= 1'H1;
            end
        end
    end

    // ======================================================================
    // read burst output sequencer
    srbp_pkg::srbp_out_st_t out_st;
    srbp_pkg::srbp_line_t   rd_line;
    srbp_pkg::srbp_idx_t    wcnt;
    logic                   first_edge;

    // loop on: first word on the negative output rise, else on the positive
    assign first_edge  = dll_on ? out_n : out_p;
    // single clock, loop off: the arming input rise is also the launch edge
    assign start_burst = (pend_go | arm_now) & first_edge &
                         (out_st != srbp_pkg::SRBP_OUT_RUN);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            out_st  <= srbp_pkg::SRBP_OUT_IDLE;
            rd_line <= '0;
            wcnt    <= 2'H0;
            o_q     <= `SRBP_RST_Q;
            o_q_oe  <= `SRBP_RST_OE;
        end else if (start_burst) begin
            // back-to-back bursts chain straight out of drain
            rd_line <= mem[pend_addr];
            o_q     <= get_word(mem[pend_addr], 2'H0);
            o_q_oe  <= 1'H1;
            wcnt    <= 2'H1;
            out_st  <= srbp_pkg::SRBP_OUT_RUN;
        end else begin
            unique case (out_st)
                srbp_pkg::SRBP_OUT_IDLE: begin
                    wcnt <= 2'H0;
                end
                srbp_pkg::SRBP_OUT_RUN: begin
                    if (out_p || out_n) begin
                        o_q  <= get_word(rd_line, wcnt);
                        wcnt <= wcnt + 2'H1;
                        if (wcnt == `SRBP_LAST_WORD) begin
                            out_st <= srbp_pkg::SRBP_OUT_DRAIN;
                        end
                    end
                end
                srbp_pkg::SRBP_OUT_DRAIN: begin
                    if (out_p) begin
                        o_q_oe <= 1'H0;
                        out_st <= srbp_pkg::SRBP_OUT_IDLE;
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // write capture: four words over two input cycles, then one line store
    logic                     wr_last;
    logic                     wr_acc;
    logic                     wr_busy;
    logic                     wr_next;
    srbp_pkg::srbp_idx_t      wr_idx;
    logic [`SRBP_ADDR_W-1:0]  wr_addr;
    logic [`SRBP_ADDR_W-1:0]  wr_next_addr;
    srbp_pkg::srbp_word_t     wr_buf [0:2];
    logic [`SRBP_BWS_W-1:0]   wr_mask [0:2];
    logic                     wr_take;
    logic                     wr_commit;
    srbp_pkg::srbp_line_t     next_line;

    assign wr_acc    = k_rise & ~wps_n & ~wr_last;
    assign wr_take   = wr_busy & (wr_idx[0] ? kn_rise : k_rise);
    assign wr_commit = wr_take & (wr_idx == `SRBP_LAST_WORD);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_last <= 1'H0;
        end else if (k_rise) begin
            wr_last <= wr_acc;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_busy      <= 1'H0;
            wr_next      <= 1'H0;
            wr_idx       <= 2'H0;
            wr_addr      <= '0;
            wr_next_addr <= '0;
        end else begin
            if (wr_acc && !wr_busy) begin
                wr_busy <= 1'H1;
                wr_addr <= addr;
                wr_idx  <= 2'H0;
            end else if (wr_acc) begin
                // a write issued while the previous one is still collecting data
                wr_next      <= 1'H1;
                wr_next_addr <= addr;
            end
            if (wr_take) begin
                wr_idx <= wr_idx + 2'H1;
            end
            if (wr_commit) begin
                wr_busy <= wr_next | wr_acc;
                wr_addr <= wr_acc ? addr : wr_next_addr;
                wr_next <= 1'H0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (wr_take && wr_idx != `SRBP_LAST_WORD) begin
            wr_buf[wr_idx]  <= din;
            wr_mask[wr_idx] <= bws_n;
        end
    end

    always_comb begin
        next_line = mem[wr_addr];
        for (int i = 0; i < 3; i++) begin
            next_line[i*`SRBP_WORD_W +: `SRBP_WORD_W] =
                merge_word(get_word(mem[wr_addr], 2'(i)), wr_buf[i], wr_mask[i]);
        end
        next_line[54 +: `SRBP_WORD_W] = merge_word(get_word(mem[wr_addr], 2'H3), din, bws_n);
    end

    always_ff @(posedge i_clk) begin
        if (wr_commit) begin
            mem[wr_addr] <= next_line;
        end
    end

    // ======================================================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_read_spacing_ok: assert property (
        k_rise && rd_last |-> !rd_acc
    ) else $error("read accepted on consecutive input rises");

    a_first_word_edge: assert property (
        start_burst |-> (dll_on ? out_n : out_p) && (pend_go || k_rise && pend_wait)
    ) else $error("burst started on wrong output edge");

    a_start_needs_rise: assert property (
        $rose(pend_go) |-> $past(k_rise) && $past(pend_wait)
    ) else $error("burst armed without a following input rise");

    a_oe_after_start: assert property (
        start_burst |=> o_q_oe && out_st == srbp_pkg::SRBP_OUT_RUN && wcnt == 2'H1
    ) else $error("outputs not driven after burst start");

    a_float_on_pos: assert property (
        $fell(o_q_oe) |-> $past(out_p) && $past(out_st) == srbp_pkg::SRBP_OUT_DRAIN
    ) else $error("outputs floated off the positive output rise");

    a_data_on_edge: assert property (
        $changed(o_q) |-> $past(out_p) || $past(out_n)
    ) else $error("read data changed without an output rise");

    a_burst_four_words: assert property (
        out_st == srbp_pkg::SRBP_OUT_RUN && (out_p || out_n) && wcnt == 2'H3
        |=> out_st == srbp_pkg::SRBP_OUT_DRAIN || start_burst
    ) else $error("burst did not end after four words");

    a_strap_stable: assert property (
        ##1 $stable(single_mode)
    ) else $error("single clock strap changed in operation");

    a_commit_on_neg: assert property (
        wr_commit |-> kn_rise && wr_busy
    ) else $error("write line stored off a negative input rise");

endmodule : srbp_read_port
`default_nettype wire

// ---- verification/srbp_ctrl_model.sv ----
// controller model: link clocks, port selects, address and write data for the sram core
`timescale 1ns/1ns
`default_nettype none
`include "srbp_cfg.svh"

module srbp_ctrl_model (
    input  wire logic                i_single,              // hold output clocks high
    output logic                     o_in_clk_pos,          // positive input clock
    output logic                     o_in_clk_neg,          // negative input clock
    output logic                     o_out_clk_pos,         // positive output clock
    output logic                     o_out_clk_neg,         // negative output clock
    output logic                     o_read_port_select_n,  // read request
    output logic                     o_write_port_select_n, // write request
    output logic [`SRBP_BWS_W-1:0]   o_byte_write_select_n, // byte lanes
    output logic [`SRBP_ADDR_W-1:0]  o_addr,                // shared address
    output logic [`SRBP_WORD_W-1:0]  o_d                    // write data
);
    // write words waiting for their half-period slot
    logic [`SRBP_BWS_W+`SRBP_WORD_W-1:0] dq[$];

    // ========================================
    // clocks run free; output pair lags by 16 ns, both high only for the single clock strap
    initial begin
        o_in_clk_pos = 1'H0;
        o_in_clk_neg = 1'H1;
        #8;
        forever begin
            o_in_clk_pos = ~o_in_clk_pos;
            o_in_clk_neg = ~o_in_clk_neg;
            #32;
        end
    end

    logic c_ph;

    assign o_out_clk_pos = c_ph | i_single;
    assign o_out_clk_neg = ~c_ph | i_single;

    initial begin
        c_ph = 1'H0;
        #24;
        forever begin
            c_ph = ~c_ph;
            #32;
        end
    end

    initial begin
        o_read_port_select_n  = 1'H1;
        o_write_port_select_n = 1'H1;
        o_byte_write_select_n = 2'H3;
        o_addr                = 20'H00000;
        o_d                   = 18'H00000;
    end

    // ========================================
    // idle data lines carry a fresh pattern, never the last word
    task automatic drive_d(input logic [31:0] fill);
        if (dq.size() != 0) begin
            {o_byte_write_select_n, o_d} = dq.pop_front();
        end else begin
            {o_byte_write_select_n, o_d} = fill[19:0];
        end
    endtask : drive_d

    // one input clock period; pins change 8 ns after each input clock rise
    task automatic slot(
        input logic                     rd,
        input logic                     wr,
        input logic [`SRBP_ADDR_W-1:0]  a,
        input logic [`SRBP_LINE_W-1:0]  line,
        input logic [7:0]               mask_n,
        input logic [31:0]              fill
    );
        @(posedge o_in_clk_pos);
        #8;
        o_read_port_select_n  = ~rd;
        o_write_port_select_n = ~wr;
        o_addr                = (rd | wr) ? a : fill[31:12];
        drive_d(fill);
        // first write word belongs to the input rise after the accepting one
        while (wr && dq.size() < 2) begin
            dq.push_back({2'H3, fill[17:0]});
        end
        for (int i = 0; i < 4; i++) begin
            if (wr) begin
                dq.push_back({mask_n[2*i+:2], line[18*i+:18]});
            end
        end
        #32;
        drive_d(~fill);
    endtask : slot
endmodule : srbp_ctrl_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// testbench for the burst sram read port: controller model, reference model, scoreboard
`timescale 1ns/1ns
`default_nettype none
`include "srbp_cfg.svh"

module tb_top;
    logic                     i_clk;
    logic                     i_srst;
    logic                     loop_n;
    logic                     single;
    logic                     kp;
    logic                     kn;
    logic                     cp;
    logic                     cn;
    logic                     rd_sel_n;
    logic                     wr_sel_n;
    logic [`SRBP_BWS_W-1:0]   lane_n;
    logic [`SRBP_ADDR_W-1:0]  addr;
    logic [`SRBP_WORD_W-1:0]  d;
    logic [`SRBP_WORD_W-1:0]  o_q;
    logic                     o_q_oe;
    logic [31:0]              rng = 32'H00004F78;
    logic [31:0]              r;
    int                       n_errors = 0;
    int                       checks = 0;
    int                       kcount = 0;
    int                       cycles = 0;
    int                       last_rd = -10;
    int                       ek[$];
    bit                       epos[$];
    logic [`SRBP_WORD_W-1:0]  ew[$];
    logic [`SRBP_LINE_W-1:0]  mem[logic [`SRBP_ADDR_W-1:0]];
    logic [`SRBP_ADDR_W-1:0]  adr[8];

    srbp_ctrl_model i_srbp_ctrl_model (
        .i_single              (single),
        .o_in_clk_pos          (kp),
        .o_in_clk_neg          (kn),
        .o_out_clk_pos         (cp),
        .o_out_clk_neg         (cn),
        .o_read_port_select_n  (rd_sel_n),
        .o_write_port_select_n (wr_sel_n),
        .o_byte_write_select_n (lane_n),
        .o_addr                (addr),
        .o_d                   (d)
    );

    srbp_read_port i_srbp_read_port (
        .i_clk                 (i_clk),
        .i_srst                (i_srst),
        .i_in_clk_pos          (kp),
        .i_in_clk_neg          (kn),
        .i_out_clk_pos         (cp),
        .i_out_clk_neg         (cn),
        .i_loop_disable_n      (loop_n),
        .i_read_port_select_n  (rd_sel_n),
        .i_write_port_select_n (wr_sel_n),
        .i_byte_write_select_n (lane_n),
        .i_addr                (addr),
        .i_d                   (d),
        .o_q                   (o_q),
        .o_q_oe                (o_q_oe)
    );

    // ========================================
    // clock, link rise counter, timeout
    initial begin
        i_clk = 1'H0;
        forever begin
            #4;
            i_clk = ~i_clk;
        end
    end

    always @(posedge kp) begin
        kcount = kcount + 1;
        if (single) fork sample(1'H1, kcount); join_none
    end

    always @(posedge i_clk) begin
        cycles = cycles + 1;
        if (cycles == 25000) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end

    // ========================================
    // helpers
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic idle(input int n);
        repeat (n) i_srbp_ctrl_model.slot(1'H0, 1'H0, 20'H00000, '0, 8'HFF, rnd());
    endtask : idle

    task automatic do_reset();
        i_srst = 1'H1;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_srst = 1'H0;
        idle(2);
    endtask : do_reset

    // reference memory keeps lanes whose select is high
    task automatic wr_line(input logic [`SRBP_ADDR_W-1:0] a, input logic [7:0] mask_n);
        logic [95:0]              raw;
        logic [`SRBP_LINE_W-1:0]  cur;
        raw = {rnd(), rnd(), rnd()};
        cur = mem.exists(a) ? mem[a] : {`SRBP_LINE_W{1'HX}};
        for (int i = 0; i < 8; i++) begin
            if (!mask_n[i]) begin
                cur[9*i+:9] = raw[9*i+:9];
            end
        end
        mem[a] = cur;
        i_srbp_ctrl_model.slot(1'H0, 1'H1, a, raw[71:0], mask_n, rnd());
        idle(1);
    endtask : wr_line

    // word i of a read taken at rise t: half-step 2+i+loop after t
    task automatic rd(input logic [`SRBP_ADDR_W-1:0] a);
        int t;
        i_srbp_ctrl_model.slot(1'H1, 1'H0, a, mem[a], 8'HFF, rnd());
        t = kcount + 1;
        if (t != last_rd + 1) begin
            last_rd = t;
            for (int i = 0; i < 4; i++) begin
                ek.push_back(t + (2 + i + int'(loop_n)) / 2);
                epos.push_back(((i + int'(loop_n)) % 2) == 0);
                ew.push_back(mem[a][18*i+:18]);
            end
        end
    endtask : rd

    // look at the word well after the output rise that launched it
    task automatic sample(input bit pos, input int k);
        #48;
        if (ek.size() != 0 && ek[0] == k && epos[0] == pos) begin
            check(o_q_oe, 18'H00001);
            check(o_q, ew[0]);
            void'(ek.pop_front());
            void'(epos.pop_front());
            void'(ew.pop_front());
        end else if (pos) begin
            check(o_q_oe, 18'H00000);
        end
    endtask : sample

    always @(posedge cp) if (!single) fork sample(1'H1, kcount); join_none
    always @(posedge cn) if (!single) fork sample(1'H0, kcount); join_none
    always @(posedge kn) if (single) fork sample(1'H0, kcount); join_none

    // ========================================
    // main sequence
    initial begin
        single = 1'H0;
        loop_n = 1'H0;
        do_reset();
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            adr[i] = r[19:0];
            wr_line(adr[i], 8'H00);
        end
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            wr_line(adr[i], r[7:0]);
        end
        idle(4);
        // passes: dual clock loop off, loop on, then single clock loop off, loop on
        for (int p = 0; p < 4; p++) begin
            if (p == 2) begin
                single = 1'H1;
                loop_n = 1'H0;
                do_reset();
            end
            for (int i = 0; i < 8; i++) begin
                rd(adr[i]);
                if (i == 3) begin
                    rd(adr[7]);
                end else begin
                    idle(1);
                end
            end
            idle(8);
            if (p % 2 == 0) begin
                loop_n = 1'H1;
                idle(1024);
            end
        end
        check(18'(ek.size()), 18'H00000);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
